// ===== rhps_pkg.sv
// package for the root hub port status block
package rhps_pkg;
    localparam logic [7:0] RHPS_PORT1_OFS = 8'h54;
    localparam logic [7:0] RHPS_PORT_STRIDE = 8'h04;
    localparam int RHPS_NUM_PORTS = 2;
    localparam int RHPS_BIT_CONNECT = 0;
    localparam int RHPS_BIT_ENABLE = 1;
    localparam int RHPS_BIT_SUSPEND = 2;
    localparam int RHPS_BIT_OVERCUR = 3;
    localparam int RHPS_BIT_RESET = 4;
    localparam int RHPS_BIT_POWER = 8;
    localparam int RHPS_BIT_SLOW = 9;
    localparam int RHPS_BIT_CONNECT_CHG = 16;
    localparam int RHPS_BIT_ENABLE_CHG = 17;
    localparam logic [31:0] RHPS_STATUS_RESET = 32'h0000_0000;
endpackage

// ===== rhps_port.sv
// one downstream port: status flags and power control
`timescale 1ns/1ps
`default_nettype none
module rhps_port
    import rhps_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register write
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // global power commands and switching configuration
    input wire logic set_global_power,
    input wire logic clr_global_power,
    input wire logic power_switch_select,
    input wire logic per_port_power_mask,
    input wire logic fixed_device_mask,
    input wire logic hub_reset_done,
    // port side
    input wire logic device_present,
    input wire logic device_slow,
    input wire logic overcurrent,
    input wire logic hw_disable,
    input wire logic reset_done,
    // status out
    output logic [31:0] status
);
    import rhps_pkg::*;

    typedef struct packed {
        logic connect;
        logic enable;
        logic suspend;
        logic reset;
        logic power;
        logic slow;
        logic connect_chg;
        logic enable_chg;
    } rhps_port_st_t;

    rhps_port_st_t st_reg;
    rhps_port_st_t st_next;

    logic per_port_ok;
    logic global_ok;
    logic wr_set_enable;
    logic wr_set_suspend;
    logic wr_set_reset;
    logic wr_clr_connect_chg;
    logic wr_clr_enable_chg;
    logic wr_set_power;
    logic wr_clr_power;
    logic connect_event;

    always_comb
    begin
        // per-port commands only in per-port mode with the mask set
        per_port_ok = power_switch_select && per_port_power_mask;
        global_ok = !per_port_ok;
        wr_set_enable = wr_en && wr_data[RHPS_BIT_ENABLE];
        wr_set_suspend = wr_en && wr_data[RHPS_BIT_SUSPEND];
        wr_set_reset = wr_en && wr_data[RHPS_BIT_RESET];
        wr_clr_connect_chg = wr_en && wr_data[RHPS_BIT_CONNECT_CHG];
        wr_clr_enable_chg = wr_en && wr_data[RHPS_BIT_ENABLE_CHG];
        wr_set_power = wr_en && wr_data[RHPS_BIT_POWER];
        wr_clr_power = wr_en && wr_data[RHPS_BIT_SLOW];
        st_next = st_reg;
        // power: clears win over sets, overcurrent wins over all
        if ((per_port_ok && wr_set_power) || (global_ok && set_global_power))
        begin
            st_next.power = 1'b1;
        end
        if ((per_port_ok && wr_clr_power) || (global_ok && clr_global_power))
        begin
            st_next.power = 1'b0;
        end
        if (overcurrent)
        begin
            st_next.power = 1'b0;
        end
        st_next.connect = device_present;
        st_next.slow = device_present ? device_slow : 1'b0;
        if (wr_set_enable && st_reg.connect)
        begin
            st_next.enable = 1'b1;
        end
        if (wr_set_suspend && st_reg.connect)
        begin
            st_next.suspend = 1'b1;
        end
        if (wr_set_reset && st_reg.connect)
        begin
            st_next.reset = 1'b1;
        end
        if (reset_done && st_reg.reset)
        begin
            st_next.reset = 1'b0;
        end
        // only hardware disable sets the enable change flag
        if (hw_disable && st_reg.enable)
        begin
            st_next.enable = 1'b0;
            st_next.enable_chg = 1'b1;
        end
        else if (wr_clr_enable_chg)
        begin
            st_next.enable_chg = 1'b0;
        end
        if (!st_next.power)
        begin
            st_next.connect = 1'b0;
            st_next.enable = 1'b0;
            st_next.suspend = 1'b0;
            st_next.reset = 1'b0;
            st_next.slow = 1'b0;
        end
        // fixed devices report only after a hub reset
        if (fixed_device_mask)
        begin
            connect_event = hub_reset_done;
        end
        else
        begin
            connect_event = st_next.connect != st_reg.connect;
        end
        if (!st_reg.connect && (wr_set_enable || wr_set_suspend || wr_set_reset))
        begin
            connect_event = 1'b1;
        end
        // set wins over the clear in the same cycle
        if (connect_event)
        begin
            st_next.connect_chg = 1'b1;
        end
        else if (wr_clr_connect_chg)
        begin
            st_next.connect_chg = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_comb
    begin
        status = RHPS_STATUS_RESET;
        status[RHPS_BIT_CONNECT] = st_reg.connect;
        status[RHPS_BIT_ENABLE] = st_reg.enable;
        status[RHPS_BIT_SUSPEND] = st_reg.suspend;
        status[RHPS_BIT_RESET] = st_reg.reset;
        status[RHPS_BIT_OVERCUR] = overcurrent;
        status[RHPS_BIT_POWER] = st_reg.power;
        status[RHPS_BIT_SLOW] = st_reg.slow;
        status[RHPS_BIT_CONNECT_CHG] = st_reg.connect_chg;
        status[RHPS_BIT_ENABLE_CHG] = st_reg.enable_chg;
    end
endmodule
`default_nettype wire

// ===== rhps_top.sv
// root hub port status registers for all downstream ports
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - connect or disconnect sets the connect change flag, bit 16.
// - writing one clears connect change; zero is ignored.
// - set reset/enable/suspend on a disconnected port sets connect change.
// - with fixed device mask, connect or disconnect does not set connect change; hub reset does.
// - bit 9 reads one for a low speed device, zero full speed.
// - writing one to bit 9 clears port power.
// - bit 8 reads the port power state.
// - overcurrent clears port power.
// - port power set and cleared by port or global power commands.
// - global switching mode: only global commands act on power.
// - per-port mode: mask set obeys port commands, clear obeys global.
// - power off holds connect, enable, suspend, reset at reset state.
// - writing one to bit 8 sets port power.
// - enable change sets only on hardware clearing of enable.
module rhps_top
    import rhps_pkg::*;
#(
    parameter int NUM_PORTS = RHPS_NUM_PORTS
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // global power control and switching configuration
    input wire logic set_global_power,
    input wire logic clr_global_power,
    input wire logic power_switch_select,
    input wire logic [NUM_PORTS-1:0] per_port_power_mask,
    input wire logic [NUM_PORTS-1:0] fixed_device_mask,
    input wire logic hub_reset_done,
    // port side
    input wire logic [NUM_PORTS-1:0] device_present,
    input wire logic [NUM_PORTS-1:0] device_slow,
    input wire logic [NUM_PORTS-1:0] overcurrent,
    input wire logic [NUM_PORTS-1:0] hw_disable,
    input wire logic [NUM_PORTS-1:0] reset_done,
    output logic [NUM_PORTS-1:0] port_power,
    output logic [NUM_PORTS-1:0] port_enable
);
    import rhps_pkg::*;

    // the offset map runs out of the 8-bit address space beyond 43 ports; the check below caps NUM_PORTS at fifteen
    generate
        if (NUM_PORTS < 1 || NUM_PORTS > 15)
        begin : g_bad_ports
            $error("rhps_top: NUM_PORTS out of range");
        end
    endgenerate

    typedef struct packed {
        logic [31:0] rdata;
    } rhps_top_st_t;

    rhps_top_st_t st_reg;
    rhps_top_st_t st_next;
    logic [31:0] port_status [NUM_PORTS];

    //////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_port
            localparam logic [7:0] PORT_OFS = 8'(RHPS_PORT1_OFS + gi * RHPS_PORT_STRIDE);
            logic hit;
            assign hit = reg_wr && (reg_addr == PORT_OFS);
            rhps_port u_port (
                .mclk(mclk),
                .arst_n(arst_n),
                .wr_en(hit),
                .wr_data(reg_wdata),
                .set_global_power(set_global_power),
                .clr_global_power(clr_global_power),
                .power_switch_select(power_switch_select),
                .per_port_power_mask(per_port_power_mask[gi]),
                .fixed_device_mask(fixed_device_mask[gi]),
                .hub_reset_done(hub_reset_done),
                .device_present(device_present[gi]),
                .device_slow(device_slow[gi]),
                .overcurrent(overcurrent[gi]),
                .hw_disable(hw_disable[gi]),
                .reset_done(reset_done[gi]),
                .status(port_status[gi])
            );
            assign port_power[gi] = port_status[gi][RHPS_BIT_POWER];
            assign port_enable[gi] = port_status[gi][RHPS_BIT_ENABLE];
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // read data registered; unmapped offsets read zero
    always_comb
    begin
        st_next = st_reg;
        if (reg_rd)
        begin
            st_next.rdata = RHPS_STATUS_RESET;
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                if (reg_addr == 8'(RHPS_PORT1_OFS + i * RHPS_PORT_STRIDE))
                begin
                    st_next.rdata = port_status[i];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
endmodule
`default_nettype wire

// ===== rhps_checker.sv
// assertions on the root hub port status top ports
`timescale 1ns/1ps
`default_nettype none
module rhps_checker
    import rhps_pkg::*;
#(
    parameter int NUM_PORTS = RHPS_NUM_PORTS
)
(
    // clock, reset and register access
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // power control and port side
    input wire logic set_global_power,
    input wire logic clr_global_power,
    input wire logic power_switch_select,
    input wire logic [NUM_PORTS-1:0] per_port_power_mask,
    input wire logic [NUM_PORTS-1:0] overcurrent,
    input wire logic [NUM_PORTS-1:0] hw_disable,
    input wire logic [NUM_PORTS-1:0] port_power,
    input wire logic [NUM_PORTS-1:0] port_enable
);
    wire logic wr0 = reg_wr && reg_addr == RHPS_PORT1_OFS;
    wire logic own0 = power_switch_select && per_port_power_mask[0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_port_wr0;
        wr0 && own0;
    endsequence
    AST_PORT_SET: assert property (s_port_wr0 ##0 (reg_wdata[9:8] == 2'b01 && !overcurrent[0])
        |=> port_power[0])
        else $error("port power set write lost");
    AST_PORT_CLR: assert property (s_port_wr0 ##0 reg_wdata[9] |=> !port_power[0])
        else $error("port power clear write lost");
    AST_OC: assert property (overcurrent[0] |=> !port_power[0])
        else $error("overcurrent left power on");
    AST_GLOB_SET: assert property (set_global_power && !clr_global_power && !overcurrent[0] && !own0
        |=> port_power[0])
        else $error("global power set lost");
    AST_GLOB_MODE: assert property (!power_switch_select && !set_global_power && !clr_global_power
        && !overcurrent[0] |=> $stable(port_power[0]))
        else $error("power moved without global command");
    AST_MASK_IGN: assert property (own0 && !wr0 && !overcurrent[0] |=> $stable(port_power[0]))
        else $error("masked port obeyed global command");
    AST_PWR_OFF: assert property (!port_power[0] [*2] |-> !port_enable[0])
        else $error("enable set while unpowered");
    AST_RD_PWR: assert property (reg_rd && reg_addr == RHPS_PORT1_OFS
        |=> reg_rdata[RHPS_BIT_POWER] == $past(port_power[0]))
        else $error("power bit read wrong");
    AST_HW_DIS: assert property (hw_disable[0] && port_enable[0] |=> !port_enable[0])
        else $error("hardware disable left port enabled");
endmodule
bind rhps_top rhps_checker #(.NUM_PORTS(NUM_PORTS)) rhps_checker_inst (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .set_global_power, .clr_global_power, .power_switch_select, .per_port_power_mask,
    .overcurrent, .hw_disable, .port_power, .port_enable);
`default_nettype wire

// ===== rhps_usb_dev.sv
// behavioural model of the usb devices on the downstream ports
`timescale 1ns/1ps
`default_nettype none
module rhps_usb_dev
#(
    parameter int NUM_PORTS = 2
)
(
    // bench control
    input wire logic [NUM_PORTS-1:0] plug,
    input wire logic [NUM_PORTS-1:0] low_speed,
    input wire logic [NUM_PORTS-1:0] fault,
    input wire logic [NUM_PORTS-1:0] port_power,
    // port side
    output logic [NUM_PORTS-1:0] device_present,
    output logic [NUM_PORTS-1:0] device_slow,
    output logic [NUM_PORTS-1:0] overcurrent
);
    // a device without bus power cannot pull its line up, so it vanishes
    assign device_present = plug & port_power;
    // host pull-downs hold the speed line low with nobody attached
    assign device_slow = low_speed & device_present;
    assign overcurrent = fault;
endmodule
`default_nettype wire

// ===== tb_root_hub_port_status.sv
// self-checking bench for the root hub port status block
`timescale 1ns/1ps
`default_nettype none
module tb_root_hub_port_status;
    import rhps_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic set_global_power = 1'b0;
    logic clr_global_power = 1'b0;
    logic psel = 1'b0;
    logic [1:0] ppm = 2'b00;
    logic [1:0] plug = 2'b00;
    logic [1:0] low_speed = 2'b00;
    logic [1:0] fault = 2'b00;
    logic [1:0] present;
    logic [1:0] slow;
    logic [1:0] ovc;
    logic [1:0] port_power;
    logic [1:0] port_enable;
    logic [1:0] fdm = 2'b00;
    logic hub_done = 1'b0;
    logic [1:0] hw_dis = 2'b00;
    logic [1:0] rst_done = 2'b00;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 mclk = ~mclk;
    rhps_top rhps_top_inst (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .set_global_power,
        .clr_global_power, .power_switch_select(psel), .per_port_power_mask(ppm), .fixed_device_mask(fdm),
        .hub_reset_done(hub_done), .device_present(present), .device_slow(slow), .overcurrent(ovc),
        .hw_disable(hw_dis), .reset_done(rst_done), .port_power, .port_enable);
    rhps_usb_dev rhps_usb_dev_inst (.plug, .low_speed, .fault, .port_power, .device_present(present),
        .device_slow(slow), .overcurrent(ovc));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reserved bits always go out as zero
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000);
        chk(reg_rdata, exp);
    endtask
    task automatic pulse(input logic set);
        @(negedge mclk);
        set_global_power = set;
        clr_global_power = !set;
        @(negedge mclk);
        set_global_power = 1'b0;
        clr_global_power = 1'b0;
    endtask
    task automatic t_global();
        acc(1'b1, 8'h54, 32'h0000_0100);
        rd_chk(8'h54, 32'h0000_0000);
        pulse(1'b1);
        chk(32'(port_power), 32'h0000_0003);
    endtask
    task automatic t_mask();
        psel = 1'b1;
        ppm = 2'b01;
        pulse(1'b0);
        chk(32'(port_power), 32'h0000_0001);
        acc(1'b1, 8'h54, 32'h0000_0200);
        rd_chk(8'h54, 32'h0000_0000);
        acc(1'b1, 8'h54, 32'h0000_0100);
        rd_chk(8'h54, 32'h0000_0100);
        acc(1'b1, 8'h58, 32'h0000_0100);
        chk(32'(port_power), 32'h0000_0001);
    endtask
    task automatic t_connect();
        low_speed = 2'b01;
        plug = 2'b01;
        repeat (2) @(negedge mclk);
        rd_chk(8'h54, 32'h0001_0301);
        acc(1'b1, 8'h54, 32'h0000_0000);
        rd_chk(8'h54, 32'h0001_0301);
        acc(1'b1, 8'h54, 32'h0001_0000);
        rd_chk(8'h54, 32'h0000_0301);
        fault = 2'b01;
        @(negedge mclk);
        fault = 2'b00;
        repeat (2) @(negedge mclk);
        rd_chk(8'h54, 32'h0001_0000);
    endtask
    task automatic t_disconn();
        pulse(1'b1);
        chk(32'(port_power), 32'h0000_0002);
        acc(1'b1, 8'h58, 32'h0000_0002);
        rd_chk(8'h58, 32'h0001_0100);
        rd_chk(8'h54, 32'h0001_0000);
    endtask
    task automatic t_enable();
        acc(1'b1, 8'h54, 32'h0000_0100);
        // connect must be registered before the enable write, or the port still reads as disconnected
        @(negedge mclk);
        acc(1'b1, 8'h54, 32'h0001_0002);
        rd_chk(8'h54, 32'h0000_0303);
        chk(32'(port_enable), 32'h0000_0001);
        hw_dis = 2'b01;
        @(negedge mclk);
        hw_dis = 2'b00;
        rd_chk(8'h54, 32'h0002_0301);
        chk(32'(port_enable), 32'h0000_0000);
        acc(1'b1, 8'h54, 32'h0002_0002);
        rd_chk(8'h54, 32'h0000_0303);
        acc(1'b1, 8'h54, 32'h0000_0010);
        rd_chk(8'h54, 32'h0000_0313);
        rst_done = 2'b01;
        @(negedge mclk);
        rst_done = 2'b00;
        rd_chk(8'h54, 32'h0000_0303);
        acc(1'b1, 8'h54, 32'h0000_0014);
        rd_chk(8'h54, 32'h0000_0317);
        acc(1'b1, 8'h54, 32'h0000_0200);
        rd_chk(8'h54, 32'h0001_0000);
        chk(32'(port_enable), 32'h0000_0000);
    endtask
    task automatic t_fixed();
        fdm = 2'b10;
        acc(1'b1, 8'h58, 32'h0001_0000);
        plug = 2'b11;
        repeat (2) @(negedge mclk);
        rd_chk(8'h58, 32'h0000_0101);
        hub_done = 1'b1;
        @(negedge mclk);
        hub_done = 1'b0;
        rd_chk(8'h58, 32'h0001_0101);
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        t_global();
        t_mask();
        t_connect();
        t_disconn();
        t_enable();
        t_fixed();
        give_verdict();
    end
endmodule
`default_nettype wire
